/* File: spd_pkg.sv */
// package: register map, field layout, lookup tables and states of the spin-detect config bank
package spd_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int SPD_NUM_REGS = 14;
  localparam logic [7:0] SPD_OFF [SPD_NUM_REGS] = '{
    8'h80, 8'h82, 8'h84, 8'h86, 8'h88, 8'h8a, 8'h8c,
    8'h8e, 8'h94, 8'h96, 8'h98, 8'h9a, 8'h9c, 8'h9e};
  localparam int SPD_IDX_DETECT = 0;
  localparam logic [7:0] SPD_STATUS_OFF = 8'ha0;
  localparam logic [31:0] SPD_CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] SPD_DETECT_WMASK = 32'h7fff_ffff;

  // ------------------------------------------------------------
  // detect configuration word fields
  // ------------------------------------------------------------
  localparam int SPD_ON_BIT = 30;
  localparam int SPD_BRAKE_ON_BIT = 29;
  localparam int SPD_COAST_BIT = 28;
  localparam int SPD_REV_BIT = 27;
  localparam int SPD_CATCH_BIT = 26;
  localparam int SPD_CATCH_THR_LSB = 22;
  localparam int SPD_STYLE_BIT = 21;
  localparam int SPD_EXIT_SEL_BIT = 20;
  localparam int SPD_EXIT_CUR_LSB = 17;
  localparam int SPD_BRAKE_DUR_LSB = 13;
  localparam int SPD_COAST_DUR_LSB = 9;
  localparam int SPD_EMF_LSB = 6;
  localparam int SPD_HANDOVER_LSB = 2;
  localparam int SPD_CAP_LSB = 0;

  // ------------------------------------------------------------
  // timing and lookup tables
  // ------------------------------------------------------------
  localparam int SPD_CLK_PERIOD_NS = 10;
  localparam int SPD_MS_NS = 1000000;
  localparam int SPD_MS_CYCLES = SPD_MS_NS / SPD_CLK_PERIOD_NS;
  // durations in ms
  localparam logic [13:0] SPD_DUR_MS [16] = '{
    14'd10, 14'd50, 14'd100, 14'd200, 14'd300, 14'd400, 14'd500, 14'd750,
    14'd1000, 14'd2000, 14'd3000, 14'd4000, 14'd5000, 14'd7500, 14'd10000, 14'd15000};
  // back-emf levels in mV
  localparam logic [10:0] SPD_EMF_MV [8] = '{
    11'd50, 11'd75, 11'd100, 11'd250, 11'd500, 11'd750, 11'd1000, 11'd1500};
  // currents in units of 1/16 A
  localparam logic [6:0] SPD_EXIT_CUR [8] = '{
    7'd1, 7'd2, 7'd3, 7'd5, 7'd10, 7'd20, 7'd40, 7'd80};
  localparam logic [6:0] SPD_CAP_CUR [4] = '{7'd15, 7'd25, 7'd35, 7'd50};
  // speeds in tenths of a percent of full speed
  localparam logic [9:0] SPD_HANDOVER_PM [16] = '{
    10'd25, 10'd50, 10'd75, 10'd100, 10'd125, 10'd150, 10'd200, 10'd250,
    10'd300, 10'd400, 10'd500, 10'd600, 10'd700, 10'd800, 10'd900, 10'd1000};

  typedef enum logic [2:0] {
    SPD_IDLE = 3'b000,
    SPD_DECIDE = 3'b001,
    SPD_COAST = 3'b010,
    SPD_BRAKE = 3'b011,
    SPD_REVERSE = 3'b100,
    SPD_CATCH = 3'b101,
    SPD_DONE = 3'b110
  } spd_state_t;
endpackage

/* File: spd_detect_cfg.sv */
// module: spin-detect configuration bank and its start-up decision sequencer
//
// What this block does
// - detection runs only when enable bit set
// - braking allowed only with brake enable
// - coasting allowed only with coast enable
// - reverse drive only with reverse enable
// - forward catch only with catch enable
// - brake style one turns low sides on
// - exit select zero: leave brake after time
// - exit select one: time and current both
// - brake time code picks 10 ms..15 s
// - coast time code picks 10 ms..15 s
// - standstill when emf below coded level
// - reverse hands to open loop at speed
// - reversal current cap from 2-bit code
module spd_detect_cfg
  import spd_pkg::*;
#(
  parameter int MS_CYCLES = SPD_MS_CYCLES
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic detect_start_in,
  input wire logic [10:0] emf_mv_in,
  input wire logic spin_reverse_in,
  input wire logic [9:0] speed_permille_in,
  input wire logic [6:0] phase_current_in,
  output logic [2:0] detect_state_out,
  output logic low_side_brake_out,
  output logic coast_out,
  output logic reverse_drive_out,
  output logic forward_catch_out,
  output logic [3:0] forward_catch_threshold_out,
  output logic [6:0] current_cap_out,
  output logic open_loop_handover_out,
  output logic detect_done_out
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (MS_CYCLES < 1 || MS_CYCLES > 1048576) begin : g_bad_ms
    $error("MS_CYCLES must lie between 1 and 2**20");
  end

  // ------------------------------------------------------------
  // register bus decode
  // ------------------------------------------------------------
  function automatic logic [4:0] reg_index(input logic [7:0] addr);
    logic [4:0] idx;
    idx = 5'h1f;
    for (int i = 0; i < SPD_NUM_REGS; i++) begin
      if (addr == SPD_OFF[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [13:0] dur_ms(input logic [3:0] code);
    return SPD_DUR_MS[code];
  endfunction

  logic [31:0] cfg_q [SPD_NUM_REGS];
  logic [31:0] rdata_q;
  wire logic [4:0] acc_idx = reg_index(reg_addr_in);
  wire logic acc_hit = acc_idx != 5'h1f;
  wire logic acc_status = reg_addr_in == SPD_STATUS_OFF;

  // unlisted offsets hold nothing: writes drop, reads give zero
  for (genvar g = 0; g < SPD_NUM_REGS; g++) begin : g_reg
    localparam logic [31:0] WMASK = (g == SPD_IDX_DETECT) ? SPD_DETECT_WMASK : 32'hffff_ffff;
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        cfg_q[g] <= SPD_CFG_RESET;
      end else if (reg_wr_in && acc_idx == 5'(g)) begin
        cfg_q[g] <= reg_wdata_in & WMASK;
      end
    end
  end

  // ------------------------------------------------------------
  // detect configuration fields
  // ------------------------------------------------------------
  wire logic [31:0] det_cfg = cfg_q[SPD_IDX_DETECT];
  wire logic spin_detect_on = det_cfg[SPD_ON_BIT];
  wire logic brake_allowed = det_cfg[SPD_BRAKE_ON_BIT];
  wire logic coast_allowed = det_cfg[SPD_COAST_BIT];
  wire logic reverse_spin_drive_on = det_cfg[SPD_REV_BIT];
  wire logic forward_catch_on = det_cfg[SPD_CATCH_BIT];
  wire logic [3:0] forward_catch_threshold = det_cfg[SPD_CATCH_THR_LSB +: 4];
  wire logic brake_style = det_cfg[SPD_STYLE_BIT];
  wire logic brake_exit_select = det_cfg[SPD_EXIT_SEL_BIT];
  wire logic [2:0] brake_exit_current = det_cfg[SPD_EXIT_CUR_LSB +: 3];
  wire logic [3:0] brake_duration = det_cfg[SPD_BRAKE_DUR_LSB +: 4];
  wire logic [3:0] coast_duration = det_cfg[SPD_COAST_DUR_LSB +: 4];
  wire logic [2:0] standstill_emf_level = det_cfg[SPD_EMF_LSB +: 3];
  wire logic [3:0] reverse_handover_speed = det_cfg[SPD_HANDOVER_LSB +: 4];
  wire logic [1:0] reversal_current_cap = det_cfg[SPD_CAP_LSB +: 2];

  wire logic [13:0] brake_ms = dur_ms(brake_duration);
  wire logic [13:0] coast_ms = dur_ms(coast_duration);
  wire logic standstill = emf_mv_in < SPD_EMF_MV[standstill_emf_level];
  wire logic [6:0] exit_cur = SPD_EXIT_CUR[brake_exit_current];
  wire logic [9:0] handover_pm = SPD_HANDOVER_PM[reverse_handover_speed];
  wire logic [6:0] cap_cur = SPD_CAP_CUR[reversal_current_cap];

  // ------------------------------------------------------------
  // millisecond timer, restarted on every state change
  // ------------------------------------------------------------
  spd_state_t state_q, state_d;
  logic [19:0] div_q;
  logic [13:0] ms_q;
  wire logic state_change = state_d != state_q;
  wire logic ms_tick = div_q == 20'(MS_CYCLES - 1);

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_q <= 20'h0_0000;
      ms_q <= 14'h0000;
    end else if (state_change) begin
      div_q <= 20'h0_0000;
      ms_q <= 14'h0000;
    end else begin
      div_q <= ms_tick ? 20'h0_0000 : div_q + 20'h0_0001;
      if (ms_tick && ms_q != 14'h3fff) begin
        ms_q <= ms_q + 14'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // decision sequencer
  // ------------------------------------------------------------
  // coast is tried before brake so a fast rotor bleeds energy first
  wire logic coast_done = ms_q >= coast_ms;
  wire logic brake_time_done = ms_q >= brake_ms;
  // a zero-current setting would never exit, so time alone cannot be bypassed
  wire logic brake_exit = brake_time_done &&
    (!brake_exit_select || phase_current_in < exit_cur);
  wire logic reached_handover = speed_permille_in <= handover_pm;

  always_comb begin
    state_d = state_q;
    case (state_q)
      SPD_IDLE: begin
        if (detect_start_in) begin
          state_d = spin_detect_on ? SPD_DECIDE : SPD_DONE;
        end
      end
      SPD_DECIDE: begin
        if (standstill) begin
          state_d = SPD_DONE;
        end else if (spin_reverse_in && reverse_spin_drive_on) begin
          state_d = SPD_REVERSE;
        end else if (!spin_reverse_in && forward_catch_on) begin
          state_d = SPD_CATCH;
        end else if (coast_allowed) begin
          state_d = SPD_COAST;
        end else if (brake_allowed) begin
          state_d = SPD_BRAKE;
        end else begin
          state_d = SPD_DONE;
        end
      end
      SPD_COAST: begin
        if (coast_done) begin
          state_d = brake_allowed ? SPD_BRAKE : SPD_DONE;
        end
      end
      SPD_BRAKE: begin
        if (brake_exit) begin
          state_d = SPD_DONE;
        end
      end
      SPD_REVERSE: begin
        if (reached_handover) begin
          state_d = SPD_DONE;
        end
      end
      SPD_CATCH: state_d = SPD_DONE;
      SPD_DONE: state_d = SPD_IDLE;
      default: state_d = SPD_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // state and registered outputs
  // ------------------------------------------------------------
  logic low_side_q, coast_q, reverse_q, catch_q, handover_q, done_q, stand_q;
  logic [6:0] cap_q;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_q <= SPD_IDLE;
      low_side_q <= 1'b0;
      coast_q <= 1'b0;
      reverse_q <= 1'b0;
      catch_q <= 1'b0;
      cap_q <= 7'h00;
      handover_q <= 1'b0;
      done_q <= 1'b0;
      stand_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // reserved style 0 leaves the bridge floating instead of guessing
      low_side_q <= state_d == SPD_BRAKE && brake_style;
      coast_q <= state_d == SPD_COAST;
      reverse_q <= state_d == SPD_REVERSE;
      catch_q <= state_d == SPD_CATCH;
      cap_q <= state_d == SPD_REVERSE ? cap_cur : 7'h00;
      handover_q <= state_q == SPD_REVERSE && state_d == SPD_DONE;
      done_q <= state_d == SPD_DONE;
      if (state_q == SPD_DECIDE) begin
        stand_q <= standstill;
      end
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  wire logic [31:0] status_word = {27'h000_0000, stand_q, spin_reverse_in, state_q};
  wire logic [31:0] rd_word = acc_hit ? cfg_q[acc_idx[3:0]] :
    acc_status ? status_word : 32'h0000_0000;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd_in ? rd_word : 32'h0000_0000;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign detect_state_out = state_q;
  assign low_side_brake_out = low_side_q;
  assign coast_out = coast_q;
  assign reverse_drive_out = reverse_q;
  assign forward_catch_out = catch_q;
  assign forward_catch_threshold_out = forward_catch_threshold;
  assign current_cap_out = cap_q;
  assign open_loop_handover_out = handover_q;
  assign detect_done_out = done_q;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_write_detect;
    reg_wr_in && reg_addr_in == SPD_OFF[SPD_IDX_DETECT];
  endsequence

  sequence s_read_detect;
    reg_rd_in && reg_addr_in == SPD_OFF[SPD_IDX_DETECT];
  endsequence

  a_rsvd_reads_zero: assert property (
    s_read_detect |=> reg_rdata_out[31] == 1'b0)
    else $error("reserved bit 31 read back as one");

  a_thr_readback: assert property (
    s_write_detect ##1 !reg_wr_in ##1 s_read_detect |=>
      reg_rdata_out[25:22] == $past(reg_wdata_in[25:22], 3))
    else $error("catch threshold not read back as written");

  // reads anywhere off the map must not leak a stored word
  a_unlisted_reads_zero: assert property (
    reg_rd_in && !acc_hit && !acc_status |=> reg_rdata_out == 32'h0000_0000)
    else $error("unlisted offset read back nonzero");

  a_off_skips_run: assert property (
    state_q == SPD_IDLE && detect_start_in && !spin_detect_on |=>
      state_q == SPD_DONE ##1 state_q == SPD_IDLE)
    else $error("detection ran while disabled");

  a_brake_enable_gate: assert property (
    state_q != SPD_BRAKE ##1 state_q == SPD_BRAKE |-> $past(brake_allowed))
    else $error("brake entered while brake disabled");

  a_coast_enable_gate: assert property (
    state_q != SPD_COAST ##1 state_q == SPD_COAST |-> $past(coast_allowed))
    else $error("coast entered while coast disabled");

  a_reverse_enable_gate: assert property (
    $rose(reverse_drive_out) |-> $past(reverse_spin_drive_on))
    else $error("reverse drive without enable");

  a_catch_enable_gate: assert property (
    $rose(forward_catch_out) |-> $past(forward_catch_on) && !$past(spin_reverse_in))
    else $error("forward catch without enable");

  a_catch_pulse_once: assert property (
    forward_catch_out |=> !forward_catch_out && detect_done_out)
    else $error("forward catch not a single step");

  a_low_side_style: assert property (
    low_side_brake_out |-> state_q == SPD_BRAKE && $past(brake_style))
    else $error("low sides on outside styled brake");

  a_brake_time_exit: assert property (
    state_q == SPD_BRAKE && !brake_exit_select && !$stable(ms_q) && ms_q >= brake_ms
      |=> state_q == SPD_DONE)
    else $error("brake held beyond its time");

  a_brake_cur_hold: assert property (
    state_q == SPD_BRAKE && brake_exit_select && phase_current_in >= exit_cur
      |=> state_q == SPD_BRAKE)
    else $error("brake left while current above threshold");

  a_coast_min_time: assert property (
    state_q == SPD_COAST && ms_q < coast_ms |=> state_q == SPD_COAST)
    else $error("coast ended early");

  a_coast_time_exit: assert property (
    state_q == SPD_COAST && !$stable(ms_q) && ms_q >= coast_ms |=> state_q != SPD_COAST)
    else $error("coast held beyond its time");

  a_handover_step: assert property (
    state_q == SPD_REVERSE && reached_handover |=>
      open_loop_handover_out ##1 !open_loop_handover_out)
    else $error("handover pulse missing");

  a_cap_select: assert property (
    reverse_drive_out |-> current_cap_out == $past(cap_cur))
    else $error("reversal current cap mismatch");

  a_standstill_done: assert property (
    state_q == SPD_DECIDE && standstill |=> state_q == SPD_DONE && detect_done_out)
    else $error("standstill motor not released");
endmodule

/* File: spd_detect_cfg_tb.sv */
// testbench: register bank and detect sequencer of spd_detect_cfg
module spd_detect_cfg_tb
  import spd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals and design
  // ------------------------------------------------------------
  // short ms tick keeps 10 ms at 40 cycles
  localparam int MS = 4;
  localparam logic [31:0] EN = 32'h4000_0000;
  localparam logic [31:0] BRK = 32'h2000_0000;
  localparam logic [31:0] CST = 32'h1000_0000;
  localparam logic [31:0] REV = 32'h0800_0000;
  localparam logic [31:0] CAT = 32'h0400_0000;
  localparam logic [31:0] STY = 32'h0020_0000;
  localparam logic [31:0] XSEL = 32'h0010_0000;
  logic mclk_in, sys_rst_in, reg_wr_in, reg_rd_in, detect_start_in, spin_reverse_in;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, w, d;
  logic [10:0] emf_mv_in;
  logic [9:0] speed_permille_in;
  logic [6:0] phase_current_in, current_cap_out, cap_seen;
  logic [2:0] detect_state_out;
  logic low_side_brake_out, coast_out, reverse_drive_out, forward_catch_out;
  logic open_loop_handover_out, detect_done_out;
  logic [3:0] forward_catch_threshold_out;
  int bad_count, n_checks, n_cyc, n_cst, n_brk, n_sbrk, n_rev, n_cat, n_hnd, c, h, dur;
  spd_detect_cfg #(.MS_CYCLES(MS)) u_spd_detect_cfg (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .detect_start_in(detect_start_in), .emf_mv_in(emf_mv_in),
    .spin_reverse_in(spin_reverse_in), .speed_permille_in(speed_permille_in),
    .phase_current_in(phase_current_in), .detect_state_out(detect_state_out),
    .low_side_brake_out(low_side_brake_out), .coast_out(coast_out),
    .reverse_drive_out(reverse_drive_out), .forward_catch_out(forward_catch_out),
    .forward_catch_threshold_out(forward_catch_threshold_out),
    .current_cap_out(current_cap_out), .open_loop_handover_out(open_loop_handover_out),
    .detect_done_out(detect_done_out));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // ------------------------------------------------------------
  // bus, compare and run tasks
  // ------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi);
    n_checks++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("[ERR] %0t count %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask
  // one detection run; at cycle drop_at current falls to 0 and speed to drop_spd
  task automatic run(input logic [31:0] cfg, input int drop_at, input logic [9:0] drop_spd);
    int i;
    wr(8'h80, cfg);
    {n_cst, n_brk, n_sbrk, n_rev, n_cat, n_hnd} = '0;
    cap_seen = 7'h00;
    @(posedge mclk_in);
    detect_start_in <= 1'b1;
    @(posedge mclk_in);
    detect_start_in <= 1'b0;
    for (i = 1; i < 3000; i++) begin
      #1;
      n_cst += int'(coast_out === 1'b1);
      n_brk += int'(low_side_brake_out === 1'b1);
      n_sbrk += int'(detect_state_out === 3'h3);
      n_rev += int'(reverse_drive_out === 1'b1);
      n_cat += int'(forward_catch_out === 1'b1);
      n_hnd += int'(open_loop_handover_out === 1'b1);
      if (reverse_drive_out === 1'b1) cap_seen = current_cap_out;
      if (detect_done_out === 1'b1) break;
      @(posedge mclk_in);
      if (i == drop_at) begin
        phase_current_in <= 7'h00;
        speed_permille_in <= drop_spd;
      end
    end
    n_cyc = i;
    if (i == 3000) begin
      bad_count++;
      $display("[ERR] %0t detection run never finished", $time);
      tally_and_finish();
    end
    @(posedge mclk_in);
    phase_current_in <= 7'h7f;
    speed_permille_in <= 10'h3ff;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {sys_rst_in, reg_wr_in, reg_rd_in, detect_start_in, spin_reverse_in} = 5'h10;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0;
    emf_mv_in = 11'h7ff;
    speed_permille_in = 10'h3ff;
    phase_current_in = 7'h7f;
    {bad_count, n_checks} = '0;
    void'($urandom(28));
    repeat (5) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    for (int k = 0; k < SPD_NUM_REGS; k++) begin
      rd(SPD_OFF[k], d);
      chk(d, 32'h0);
    end
    $display("test reset values done");
    for (int k = 0; k < SPD_NUM_REGS; k++) begin
      w = $urandom;
      wr(SPD_OFF[k], w);
      rd(SPD_OFF[k], d);
      chk(d, (k == 0) ? {1'b0, w[30:0]} : w);
      if (k == 0) chk({28'h0, forward_catch_threshold_out}, {28'h0, w[25:22]});
    end
    wr(8'h80, 32'hffff_ffff);
    // software only reads unlisted offsets, it never writes them
    for (int k = 0; k < 4; k++) begin
      rd(8'h81 + 8'(k * 16), d);
      chk(d, 32'h0);
    end
    rd(8'h91, d);
    chk(d, 32'h0);
    rd(8'h80, d);
    chk(d, 32'h7fff_ffff);
    $display("test register access done");
    run(32'hbfff_ffff, 0, 10'h0);
    chk_rng(n_cyc + n_cst + n_brk + n_rev + n_cat, 1, 1);
    for (c = 0; c < 8; c++) begin
      emf_mv_in <= SPD_EMF_MV[c] - 11'h1;
      run(EN | CST | (32'(c) << SPD_EMF_LSB), 0, 10'h0);
      chk_rng(n_cyc + n_cst, 2, 2);
      rd(SPD_STATUS_OFF, d);
      chk(d, 32'h0000_0010);
      emf_mv_in <= SPD_EMF_MV[c];
      run(EN | CST | (32'(c) << SPD_EMF_LSB), 0, 10'h0);
      chk_rng(n_cst, 40, 42);
      rd(SPD_STATUS_OFF, d);
      chk(d, 32'h0000_0000);
    end
    emf_mv_in <= 11'h7ff;
    $display("test enable and standstill done");
    for (c = 0; c < 3; c++) begin
      dur = int'(SPD_DUR_MS[c]) * MS;
      run(EN | CST | (32'(c) << SPD_COAST_DUR_LSB), 0, 10'h0);
      chk_rng(n_cst, dur, dur + 2);
      run(EN | BRK | STY | (32'(c) << SPD_BRAKE_DUR_LSB), 0, 10'h0);
      chk_rng(n_brk, dur, dur + 2);
    end
    run(EN | BRK | CST | STY, 0, 10'h0);
    chk_rng(n_cst + n_brk, 80, 84);
    run(EN | BRK, 0, 10'h0);
    chk_rng(n_brk, 0, 0);
    chk_rng(n_sbrk, 40, 42);
    h = $urandom % 8;
    run(EN | BRK | STY | XSEL | (32'(h) << SPD_EXIT_CUR_LSB), 150, 10'h3ff);
    chk_rng(n_brk, 145, 152);
    run(EN | STY, 0, 10'h0);
    chk_rng(n_cyc + n_brk + n_cst, 2, 2);
    $display("test coast and brake done");
    spin_reverse_in <= 1'b1;
    for (c = 0; c < 4; c++) begin
      h = $urandom % 16;
      run(EN | REV | CST | (32'(h) << SPD_HANDOVER_LSB) | 32'(c), 30, SPD_HANDOVER_PM[h]);
      chk({25'h0, cap_seen}, {25'h0, SPD_CAP_CUR[c]});
      chk_rng(n_hnd, 1, 1);
      chk_rng(n_rev, 27, 33);
    end
    run(EN | CAT, 0, 10'h0);
    chk_rng(n_rev + n_cat, 0, 0);
    spin_reverse_in <= 1'b0;
    run(EN | CAT | CST | BRK | STY, 0, 10'h0);
    chk_rng(n_cat, 1, 1);
    chk_rng(n_cst + n_brk, 0, 0);
    $display("test reverse and catch done");
    tally_and_finish();
  end
endmodule
